// [rtl/pmc_map.svh]
`ifndef PMC_MAP_SVH
`define PMC_MAP_SVH

// register byte addresses
`define PMC_ADDR_MODE_CTRL    32'h0004_0044
`define PMC_ADDR_CLK_OUT_CFG  32'h0004_0048
`define PMC_ADDR_STATUS       32'h0004_004c

// processor_mode_control field positions
`define PMC_BIT_MODE_LO       0
`define PMC_BIT_MODE_HI       1
`define PMC_BIT_STROBE_STYLE  2
`define PMC_BIT_SOFT_RESET    3
`define PMC_BIT_RSVD_LO       4
`define PMC_BIT_RSVD_HI       6
`define PMC_BIT_BCLK_DISABLE  7

// processor_mode_control reset patterns
`define PMC_RST_STRAP_LOW     8'h80
`define PMC_RST_STRAP_HIGH    8'h03

// mode field codes
`define PMC_MODE_SINGLE       2'h0
`define PMC_MODE_EXPAND       2'h1
`define PMC_MODE_FORBIDDEN    2'h2
`define PMC_MODE_MICRO        2'h3

// clock output select codes
`define PMC_CKSEL_PORT        2'h0
`define PMC_CKSEL_FC          2'h1
`define PMC_CKSEL_F8          2'h2
`define PMC_CKSEL_F32         2'h3
`define PMC_CKSEL_RESET       2'h0
`define PMC_DIV_F8_BIT        2
`define PMC_DIV_F32_BIT       4

// memory map boundaries
`define PMC_MAP_RAM_BASE      32'h0000_0400
`define PMC_MAP_SFR2_BASE     32'h0004_0000
`define PMC_MAP_RSVD_BASE     32'h0005_0000
`define PMC_MAP_DROM_BASE     32'h0006_0000
`define PMC_MAP_EXT_LO_BASE   32'h0008_0000
`define PMC_MAP_NONE_BASE     32'h0200_0000
`define PMC_MAP_EXT_HI_BASE   32'hfe00_0000
`define PMC_MAP_ROM_BASE      32'hffe0_0000

// status register field positions
`define PMC_STAT_ROM_LOCK     0
`define PMC_STAT_BUS_PINS     1
`define PMC_STAT_STRAP        2
`define PMC_STAT_INIT_DONE    3

// strap settling time after reset release, in clock cycles
`define PMC_INIT_CYCLES       3'h4

// AXI responses
`define PMC_RESP_OKAY         2'h0
`define PMC_RESP_SLVERR       2'h2

`endif

// [rtl/pmc_pkg.sv]
package pmc_pkg;

  typedef enum logic [1:0] {
    PMC_BUS_IDLE = 2'b01,
    PMC_BUS_RESP = 2'b10
  } pmc_bus_state_t;

  typedef enum logic [5:0] {
    PMC_REG_SFR  = 6'b000001,
    PMC_REG_RAM  = 6'b000010,
    PMC_REG_DROM = 6'b000100,
    PMC_REG_ROM  = 6'b001000,
    PMC_REG_EXT  = 6'b010000,
    PMC_REG_NONE = 6'b100000
  } pmc_region_t;

endpackage

// [rtl/pmc_sync.sv]
`timescale 1ns/1ps

// three-stage synchroniser; the output follows once stages two and three agree
module pmc_sync (
  input  wire logic clk_sys_in,
  input  wire logic rstn_in,
  input  wire logic async_in,
  output logic      sync_out
);

  logic meta_q;
  logic stage2_q;
  logic stage3_q;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      meta_q   <= 1'b0;
      stage2_q <= 1'b0;
      stage3_q <= 1'b0;
    end else begin
      meta_q   <= async_in;
      stage2_q <= meta_q;
      stage3_q <= stage2_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      sync_out <= 1'b0;
    end else if (stage2_q == stage3_q) begin
      sync_out <= stage3_q;
    end
  end

endmodule

// [rtl/pmc_top.sv]
// Summary of operation
// - At hardware reset release, strap low starts single-chip, strap high starts microprocessor.
// - Mode field: 00 single-chip, 01 expansion, 11 microprocessor; 10 forbidden.
// - Register reset pattern follows strap: 80h for single-chip, 03h for microprocessor.
// - After a microprocessor start, internal ROM stays locked in every later mode.
// - Strobe bit clear: read, write, four byte controls; set: read, four byte writes.
// - Writing one to the soft reset bit resets the device; bit reads zero.
// - Bus clock bit clear drives bus clock on shared pin outside single-chip; set follows clock select.
// - Single-chip mode never drives the bus clock out.
// - Single-chip frees all pins; other modes claim bus control pins.
// - Expansion reaches SFR, RAM, ROM, external; microprocessor reaches all except ROM.
// - 00080000h up to 02000000h is external outside single-chip, unexpanded in single-chip.
// - Microprocessor mode decodes the top region from FFE00000h as external.
// - 02000000h up to the upper external region is unusable in every mode.
// - Software and watchdog resets leave the mode field unchanged.
// - Reset vector low bits give bus width in microprocessor mode; start address clears them.
//
// Design decision made here: register access over AXI4-Lite.
`timescale 1ns/1ps
`include "pmc_map.svh"

module pmc_top (
  input  wire logic        clk_sys_in,
  input  wire logic        rstn_in,
  // AXI4-Lite slave
  input  wire logic [31:0] s_axi_awaddr_in,
  input  wire logic        s_axi_awvalid_in,
  output logic             s_axi_awready_out,
  input  wire logic [31:0] s_axi_wdata_in,
  input  wire logic [3:0]  s_axi_wstrb_in,
  input  wire logic        s_axi_wvalid_in,
  output logic             s_axi_wready_out,
  output logic [1:0]       s_axi_bresp_out,
  output logic             s_axi_bvalid_out,
  input  wire logic        s_axi_bready_in,
  input  wire logic [31:0] s_axi_araddr_in,
  input  wire logic        s_axi_arvalid_in,
  output logic             s_axi_arready_out,
  output logic [31:0]      s_axi_rdata_out,
  output logic [1:0]       s_axi_rresp_out,
  output logic             s_axi_rvalid_out,
  input  wire logic        s_axi_rready_in,
  // strap and reset sources
  input  wire logic        mode_strap_pin_in,
  input  wire logic        watchdog_reset_in,
  input  wire logic [31:0] reset_vector_in,
  output logic             soft_reset_req_out,
  output logic [31:0]      program_start_out,
  output logic [1:0]       ext_bus_width_out,
  // address decode
  input  wire logic [31:0] cpu_addr_in,
  output logic [5:0]       cpu_region_out,
  // external bus strobes, active low
  input  wire logic        cpu_rd_in,
  input  wire logic        cpu_wr_in,
  input  wire logic [3:0]  cpu_be_in,
  output logic             read_strobe_n_out,
  output logic             write_strobe_n_out,
  output logic [3:0]       byte_control_n_out,
  output logic [3:0]       byte_write_strobe_n_out,
  output logic             bus_pins_claimed_out,
  // shared clock pin
  input  wire logic        port_data_in,
  input  wire logic        fc_clk_in,
  output logic             shared_clock_port_pin_out
);

  logic                 strap_sync;
  logic [2:0]           init_cnt_q;
  logic                 init_done_q;
  logic                 strap_q;
  logic                 rom_lock_q;
  logic [1:0]           mode_q;
  logic                 strobe_style_q;
  logic [2:0]           rsvd_q;
  logic                 bclk_disable_q;
  logic [1:0]           clock_out_select_q;
  logic                 wdt_sync;
  pmc_pkg::pmc_bus_state_t wr_state_q;
  pmc_pkg::pmc_bus_state_t rd_state_q;
  logic                 aw_got_q;
  logic                 w_got_q;
  logic [31:0]          wr_addr_q;
  logic [7:0]           wr_byte_q;
  logic                 wr_lane0_q;
  logic                 wr_commit;
  logic                 wr_mode_hit;
  logic                 wr_cksel_hit;
  logic                 soft_reset_hit;
  logic                 any_soft_reset;
  logic [7:0]           mode_reg_view;
  logic [7:0]           upper_reset;
  logic [7:0]           strap_reset;
  logic [4:0]           div_q;
  logic                 bclk_q;
  logic                 single_chip;
  pmc_pkg::pmc_region_t region_d;

  pmc_sync u_strap_sync (
    .clk_sys_in (clk_sys_in),
    .rstn_in    (rstn_in),
    .async_in   (mode_strap_pin_in),
    .sync_out   (strap_sync)
  );

  assign single_chip   = (mode_q == `PMC_MODE_SINGLE);
  assign upper_reset   = strap_q ? `PMC_RST_STRAP_HIGH : `PMC_RST_STRAP_LOW;
  assign strap_reset   = strap_sync ? `PMC_RST_STRAP_HIGH : `PMC_RST_STRAP_LOW;
  assign mode_reg_view = {bclk_disable_q, rsvd_q, 1'b0, strobe_style_q, mode_q};

  // strap settles through the synchroniser before the mode is taken
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      init_cnt_q  <= 3'h0;
      init_done_q <= 1'b0;
      strap_q     <= 1'b0;
    end else if (!init_done_q) begin
      init_cnt_q <= init_cnt_q + 3'h1;
      if (init_cnt_q == `PMC_INIT_CYCLES) begin
        init_done_q <= 1'b1;
        strap_q     <= strap_sync;
      end
    end
  end

  // write channel
  assign wr_commit      = (wr_state_q == pmc_pkg::PMC_BUS_IDLE) && aw_got_q && w_got_q;
  assign wr_mode_hit    = wr_commit && wr_lane0_q && (wr_addr_q == `PMC_ADDR_MODE_CTRL);
  assign wr_cksel_hit   = wr_commit && wr_lane0_q && (wr_addr_q == `PMC_ADDR_CLK_OUT_CFG);
  assign soft_reset_hit = wr_mode_hit && wr_byte_q[`PMC_BIT_SOFT_RESET];
  assign any_soft_reset = soft_reset_hit || wdt_sync;

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wdt_sync <= 1'b0;
    end else begin
      wdt_sync <= watchdog_reset_in && init_done_q;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      wr_state_q        <= pmc_pkg::PMC_BUS_IDLE;
      aw_got_q          <= 1'b0;
      w_got_q           <= 1'b0;
      wr_addr_q         <= 32'h0;
      wr_byte_q         <= 8'h0;
      wr_lane0_q        <= 1'b0;
      s_axi_awready_out <= 1'b0;
      s_axi_wready_out  <= 1'b0;
      s_axi_bvalid_out  <= 1'b0;
      s_axi_bresp_out   <= `PMC_RESP_OKAY;
    end else begin
      case (wr_state_q)
        pmc_pkg::PMC_BUS_IDLE: begin
          if (s_axi_awvalid_in && s_axi_awready_out) begin
            aw_got_q          <= 1'b1;
            wr_addr_q         <= {s_axi_awaddr_in[31:2], 2'b00};
            s_axi_awready_out <= 1'b0;
          end else begin
            s_axi_awready_out <= init_done_q && !aw_got_q;
          end
          if (s_axi_wvalid_in && s_axi_wready_out) begin
            w_got_q          <= 1'b1;
            wr_byte_q        <= s_axi_wdata_in[7:0];
            wr_lane0_q       <= s_axi_wstrb_in[0];
            s_axi_wready_out <= 1'b0;
          end else begin
            s_axi_wready_out <= init_done_q && !w_got_q;
          end
          if (wr_commit) begin
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out  <= 1'b0;
            s_axi_bvalid_out  <= 1'b1;
            s_axi_bresp_out   <= ((wr_addr_q == `PMC_ADDR_MODE_CTRL) || (wr_addr_q == `PMC_ADDR_CLK_OUT_CFG) ||
                                  (wr_addr_q == `PMC_ADDR_STATUS)) ? `PMC_RESP_OKAY : `PMC_RESP_SLVERR;
            wr_state_q        <= pmc_pkg::PMC_BUS_RESP;
          end
        end
        pmc_pkg::PMC_BUS_RESP: begin
          if (s_axi_bready_in) begin
            s_axi_bvalid_out <= 1'b0;
            aw_got_q         <= 1'b0;
            w_got_q          <= 1'b0;
            wr_state_q       <= pmc_pkg::PMC_BUS_IDLE;
          end
        end
        default: begin
          wr_state_q <= pmc_pkg::PMC_BUS_IDLE;
        end
      endcase
    end
  end

  // processor_mode_control: mode field
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      mode_q <= `PMC_MODE_SINGLE;
    end else if (!init_done_q) begin
      if (init_cnt_q == `PMC_INIT_CYCLES) begin
        mode_q <= strap_sync ? `PMC_MODE_MICRO : `PMC_MODE_SINGLE;
      end
    end else if (any_soft_reset) begin
      mode_q <= mode_q;
    end else if (wr_mode_hit && (wr_byte_q[`PMC_BIT_MODE_HI:`PMC_BIT_MODE_LO] != `PMC_MODE_FORBIDDEN)) begin
      mode_q <= wr_byte_q[`PMC_BIT_MODE_HI:`PMC_BIT_MODE_LO];
    end
  end

  // processor_mode_control: upper control bits, restored by every reset kind
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      strobe_style_q <= 1'b0;
      rsvd_q         <= 3'h0;
      bclk_disable_q <= 1'b1;
    end else if (!init_done_q) begin
      if (init_cnt_q == `PMC_INIT_CYCLES) begin
        strobe_style_q <= strap_reset[`PMC_BIT_STROBE_STYLE];
        rsvd_q         <= strap_reset[`PMC_BIT_RSVD_HI:`PMC_BIT_RSVD_LO];
        bclk_disable_q <= strap_reset[`PMC_BIT_BCLK_DISABLE];
      end
    end else if (any_soft_reset) begin
      strobe_style_q <= upper_reset[`PMC_BIT_STROBE_STYLE];
      rsvd_q         <= upper_reset[`PMC_BIT_RSVD_HI:`PMC_BIT_RSVD_LO];
      bclk_disable_q <= upper_reset[`PMC_BIT_BCLK_DISABLE];
    end else if (wr_mode_hit) begin
      strobe_style_q <= wr_byte_q[`PMC_BIT_STROBE_STYLE];
      rsvd_q         <= wr_byte_q[`PMC_BIT_RSVD_HI:`PMC_BIT_RSVD_LO];
      bclk_disable_q <= wr_byte_q[`PMC_BIT_BCLK_DISABLE];
    end
  end

  // clock output select, returned to port function by any reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      clock_out_select_q <= `PMC_CKSEL_RESET;
    end else if (any_soft_reset) begin
      clock_out_select_q <= `PMC_CKSEL_RESET;
    end else if (wr_cksel_hit) begin
      clock_out_select_q <= wr_byte_q[1:0];
    end
  end

  // internal ROM lockout survives mode changes until the next hardware reset
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rom_lock_q <= 1'b0;
    end else if (!init_done_q && (init_cnt_q == `PMC_INIT_CYCLES)) begin
      rom_lock_q <= strap_sync;
    end
  end

  // soft reset request pulse; the stored bit never exists so it reads zero
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      soft_reset_req_out <= 1'b0;
    end else begin
      soft_reset_req_out <= soft_reset_hit;
    end
  end

  // read channel
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      rd_state_q        <= pmc_pkg::PMC_BUS_IDLE;
      s_axi_arready_out <= 1'b0;
      s_axi_rvalid_out  <= 1'b0;
      s_axi_rdata_out   <= 32'h0;
      s_axi_rresp_out   <= `PMC_RESP_OKAY;
    end else begin
      case (rd_state_q)
        pmc_pkg::PMC_BUS_IDLE: begin
          if (s_axi_arvalid_in && s_axi_arready_out) begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out  <= 1'b1;
            s_axi_rresp_out   <= `PMC_RESP_OKAY;
            rd_state_q        <= pmc_pkg::PMC_BUS_RESP;
            case ({s_axi_araddr_in[31:2], 2'b00})
              `PMC_ADDR_MODE_CTRL:   s_axi_rdata_out <= {24'h0, mode_reg_view};
              `PMC_ADDR_CLK_OUT_CFG: s_axi_rdata_out <= {30'h0, clock_out_select_q};
              `PMC_ADDR_STATUS: begin
                s_axi_rdata_out <= 32'h0;
                s_axi_rdata_out[`PMC_STAT_ROM_LOCK]  <= rom_lock_q;
                s_axi_rdata_out[`PMC_STAT_BUS_PINS]  <= bus_pins_claimed_out;
                s_axi_rdata_out[`PMC_STAT_STRAP]     <= strap_q;
                s_axi_rdata_out[`PMC_STAT_INIT_DONE] <= init_done_q;
              end
              default: begin
                s_axi_rdata_out <= 32'h0;
                s_axi_rresp_out <= `PMC_RESP_SLVERR;
              end
            endcase
          end else begin
            s_axi_arready_out <= init_done_q;
          end
        end
        pmc_pkg::PMC_BUS_RESP: begin
          if (s_axi_rready_in) begin
            s_axi_rvalid_out <= 1'b0;
            rd_state_q       <= pmc_pkg::PMC_BUS_IDLE;
          end
        end
        default: begin
          rd_state_q <= pmc_pkg::PMC_BUS_IDLE;
        end
      endcase
    end
  end

  // address decode for the current mode
  always_comb begin
    region_d = pmc_pkg::PMC_REG_NONE;
    if (cpu_addr_in < `PMC_MAP_RAM_BASE) begin
      region_d = pmc_pkg::PMC_REG_SFR;
    end else if (cpu_addr_in < `PMC_MAP_SFR2_BASE) begin
      region_d = pmc_pkg::PMC_REG_RAM;
    end else if (cpu_addr_in < `PMC_MAP_RSVD_BASE) begin
      region_d = pmc_pkg::PMC_REG_SFR;
    end else if (cpu_addr_in < `PMC_MAP_DROM_BASE) begin
      region_d = pmc_pkg::PMC_REG_NONE;
    end else if (cpu_addr_in < `PMC_MAP_EXT_LO_BASE) begin
      region_d = pmc_pkg::PMC_REG_DROM;
    end else if (cpu_addr_in < `PMC_MAP_NONE_BASE) begin
      region_d = single_chip ? pmc_pkg::PMC_REG_NONE : pmc_pkg::PMC_REG_EXT;
    end else if (cpu_addr_in < `PMC_MAP_EXT_HI_BASE) begin
      region_d = pmc_pkg::PMC_REG_NONE;
    end else if (cpu_addr_in < `PMC_MAP_ROM_BASE) begin
      region_d = single_chip ? pmc_pkg::PMC_REG_NONE : pmc_pkg::PMC_REG_EXT;
    end else if (mode_q == `PMC_MODE_MICRO) begin
      region_d = pmc_pkg::PMC_REG_EXT;
    end else if (rom_lock_q) begin
      region_d = pmc_pkg::PMC_REG_NONE;
    end else begin
      region_d = pmc_pkg::PMC_REG_ROM;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      cpu_region_out <= pmc_pkg::PMC_REG_NONE;
    end else begin
      cpu_region_out <= region_d;
    end
  end

  // bus control pins and strobe style
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bus_pins_claimed_out    <= 1'b0;
      read_strobe_n_out       <= 1'b1;
      write_strobe_n_out      <= 1'b1;
      byte_control_n_out      <= 4'hf;
      byte_write_strobe_n_out <= 4'hf;
    end else begin
      bus_pins_claimed_out <= !single_chip;
      if (single_chip) begin
        read_strobe_n_out       <= 1'b1;
        write_strobe_n_out      <= 1'b1;
        byte_control_n_out      <= 4'hf;
        byte_write_strobe_n_out <= 4'hf;
      end else if (!strobe_style_q) begin
        read_strobe_n_out       <= !cpu_rd_in;
        write_strobe_n_out      <= !cpu_wr_in;
        byte_control_n_out      <= ~cpu_be_in;
        byte_write_strobe_n_out <= 4'hf;
      end else begin
        read_strobe_n_out       <= !cpu_rd_in;
        write_strobe_n_out      <= 1'b1;
        byte_control_n_out      <= 4'hf;
        byte_write_strobe_n_out <= ~(cpu_be_in & {4{cpu_wr_in}});
      end
    end
  end

  // bus clock and divided clocks for the shared pin
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      bclk_q <= 1'b0;
      div_q  <= 5'h0;
    end else begin
      bclk_q <= !bclk_q;
      div_q  <= div_q + 5'h1;
    end
  end

  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      shared_clock_port_pin_out <= 1'b0;
    end else if (!bclk_disable_q) begin
      shared_clock_port_pin_out <= single_chip ? port_data_in : bclk_q;
    end else begin
      case (clock_out_select_q)
        `PMC_CKSEL_PORT: shared_clock_port_pin_out <= single_chip ? port_data_in : 1'b0;
        `PMC_CKSEL_FC:   shared_clock_port_pin_out <= fc_clk_in;
        `PMC_CKSEL_F8:   shared_clock_port_pin_out <= div_q[`PMC_DIV_F8_BIT];
        `PMC_CKSEL_F32:  shared_clock_port_pin_out <= div_q[`PMC_DIV_F32_BIT];
        default:         shared_clock_port_pin_out <= 1'b0;
      endcase
    end
  end

  // reset vector split
  always_ff @(posedge clk_sys_in or negedge rstn_in) begin
    if (!rstn_in) begin
      program_start_out <= 32'h0;
      ext_bus_width_out <= 2'h0;
    end else begin
      program_start_out <= {reset_vector_in[31:2], 2'b00};
      ext_bus_width_out <= (mode_q == `PMC_MODE_MICRO) ? reset_vector_in[1:0] : 2'h0;
    end
  end

endmodule

// [tb/pmc_ext_mem.sv]
`timescale 1ns/1ps
module pmc_ext_mem (
  input  wire logic       clk_sys_in,
  input  wire logic       write_strobe_n_out,
  input  wire logic [3:0] byte_write_strobe_n_out,
  output int              ext_wr_count
);
  logic idle_q;
  wire  idle = write_strobe_n_out & (&byte_write_strobe_n_out);
  initial ext_wr_count = 0;
  // one count per write cycle in either strobe style
  always @(posedge clk_sys_in) begin
    idle_q <= idle;
    if (idle_q === 1'b1 && idle === 1'b0) ext_wr_count <= ext_wr_count + 1;
  end
endmodule

// [tb/pmc_properties.sv]
`timescale 1ns/1ps
module pmc_chk (
  input wire logic        clk_sys_in,
  input wire logic        rstn_in,
  input wire logic        s_axi_awvalid_in,
  input wire logic        s_axi_awready_out,
  input wire logic        s_axi_wvalid_in,
  input wire logic        s_axi_wready_out,
  input wire logic        s_axi_bvalid_out,
  input wire logic        s_axi_bready_in,
  input wire logic [1:0]  s_axi_bresp_out,
  input wire logic        s_axi_arvalid_in,
  input wire logic        s_axi_arready_out,
  input wire logic        s_axi_rvalid_out,
  input wire logic        soft_reset_req_out,
  input wire logic [31:0] reset_vector_in,
  input wire logic [31:0] program_start_out,
  input wire logic [31:0] cpu_addr_in,
  input wire logic [5:0]  cpu_region_out,
  input wire logic        bus_pins_claimed_out,
  input wire logic        read_strobe_n_out,
  input wire logic        write_strobe_n_out,
  input wire logic [3:0]  byte_write_strobe_n_out
);
  default clocking cb @(posedge clk_sys_in); endclocking
  default disable iff (!rstn_in);
  wire aw_w = s_axi_awvalid_in & s_axi_awready_out & s_axi_wvalid_in & s_axi_wready_out;
  wire lo_ext = cpu_addr_in >= 32'h0008_0000 && cpu_addr_in < 32'h0200_0000;
  wire gap = cpu_addr_in >= 32'h0200_0000 && cpu_addr_in < 32'hfe00_0000;
  wire idle = read_strobe_n_out & write_strobe_n_out & (&byte_write_strobe_n_out);
  property p_bresp; aw_w |-> ##2 s_axi_bvalid_out; endproperty
  a_bresp: assert property (p_bresp) else $error("write response late");
  property p_bhold; s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out && $stable(s_axi_bresp_out); endproperty
  a_bhold: assert property (p_bhold) else $error("write response dropped");
  property p_rvld; s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out; endproperty
  a_rvld: assert property (p_rvld) else $error("read data late");
  property p_soft; soft_reset_req_out |=> !soft_reset_req_out; endproperty
  a_soft: assert property (p_soft) else $error("soft reset pulse too long");
  property p_start; $past(rstn_in) |-> program_start_out == ($past(reset_vector_in) & 32'hffff_fffc); endproperty
  a_start: assert property (p_start) else $error("program start wrong");
  property p_gap; gap |=> cpu_region_out == 6'h20; endproperty
  a_gap: assert property (p_gap) else $error("unusable range decoded");
  property p_scext; !bus_pins_claimed_out && lo_ext ##1 !bus_pins_claimed_out |-> cpu_region_out != 6'h10; endproperty
  a_scext: assert property (p_scext) else $error("single-chip expanded");
  property p_scstb; !bus_pins_claimed_out ##1 !bus_pins_claimed_out |-> idle; endproperty
  a_scstb: assert property (p_scstb) else $error("strobe in single-chip");
  c_wr: cover property (s_axi_bvalid_out && s_axi_bready_in);
  c_soft: cover property (soft_reset_req_out);
  c_claim: cover property ($rose(bus_pins_claimed_out));
endmodule

bind pmc_top pmc_chk u_chk (.*);

// [tb/tb.sv]
`timescale 1ns/1ps
module tb;
  localparam logic [31:0] MC = 32'h0004_0044;
  localparam logic [31:0] CK = 32'h0004_0048;
  localparam logic [31:0] ST = 32'h0004_004c;
  logic clk_sys_in, rstn_in, mode_strap_pin_in, watchdog_reset_in, port_data_in, fc_clk_in, tog;
  logic s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in;
  logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out, s_axi_rvalid_out;
  logic [31:0] s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, s_axi_rdata_out;
  logic [31:0] reset_vector_in, program_start_out, cpu_addr_in;
  logic [3:0]  s_axi_wstrb_in, cpu_be_in, byte_control_n_out, byte_write_strobe_n_out;
  logic [1:0]  s_axi_bresp_out, s_axi_rresp_out, ext_bus_width_out;
  logic [5:0]  cpu_region_out;
  logic soft_reset_req_out, cpu_rd_in, cpu_wr_in, read_strobe_n_out, write_strobe_n_out;
  logic bus_pins_claimed_out, shared_clock_port_pin_out;
  int   ext_wr_count, fail_count, cmp_count;

  pmc_top DUT (.*);
  pmc_ext_mem u_mem (.*);

  initial begin
    clk_sys_in = 1'b0;
    forever #5 clk_sys_in = ~clk_sys_in;
  end

  task automatic chk(input logic [31:0] g, e);
    cmp_count++;
    if (g !== e) begin
      fail_count++;
      $display("BAD t=%0t got %h exp %h", $time, g, e);
    end
  endtask

  task automatic end_of_test;
    $display("comparisons %0d mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // one bus access; waits for the answer with no count of its own
  task automatic acc(input logic w, input logic [31:0] a, d, ed, input logic [1:0] er);
    if (w) begin
      s_axi_awaddr_in <= a;
      s_axi_wdata_in <= d;
      s_axi_awvalid_in <= 1'b1;
      s_axi_wvalid_in <= 1'b1;
      s_axi_bready_in <= 1'b1;
    end else begin
      s_axi_araddr_in <= a;
      s_axi_arvalid_in <= 1'b1;
      s_axi_rready_in <= 1'b1;
    end
    do begin
      @(posedge clk_sys_in);
      if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'b0;
      if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'b0;
      if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'b0;
    end while (!(w ? s_axi_bvalid_out === 1'b1 : s_axi_rvalid_out === 1'b1));
    s_axi_bready_in <= 1'b0;
    s_axi_rready_in <= 1'b0;
    chk(w ? s_axi_bresp_out : s_axi_rresp_out, er);
    if (!w) chk(s_axi_rdata_out, ed);
    @(posedge clk_sys_in);
  endtask

  task automatic wr(input logic [31:0] a, d);
    acc(1'b1, a, d, 32'h0, 2'h0);
  endtask

  task automatic rd(input logic [31:0] a, e);
    acc(1'b0, a, 32'h0, e, 2'h0);
  endtask

  task automatic rst(input logic s);
    rstn_in <= 1'b0;
    mode_strap_pin_in <= s;
    repeat (20) @(posedge clk_sys_in);
    rstn_in <= 1'b1;
    repeat (8) @(posedge clk_sys_in);
  endtask

  task automatic ra(input logic [31:0] a, input logic [5:0] e);
    cpu_addr_in <= a;
    repeat (2) @(posedge clk_sys_in);
    chk(cpu_region_out, e);
  endtask

  task automatic stb(input logic [8:0] e);
    {cpu_rd_in, cpu_wr_in} <= 2'b11;
    repeat (2) @(posedge clk_sys_in);
    chk({read_strobe_n_out, write_strobe_n_out, byte_control_n_out, byte_write_strobe_n_out}, {1'b0, e});
    {cpu_rd_in, cpu_wr_in} <= 2'b00;
    @(posedge clk_sys_in);
  endtask

  task automatic pn(input logic p, f, e);
    port_data_in <= p;
    fc_clk_in <= f;
    repeat (3) @(posedge clk_sys_in);
    chk(shared_clock_port_pin_out, e);
  endtask

  initial begin
    repeat (20000) @(posedge clk_sys_in);
    fail_count++;
    end_of_test();
  end

  initial begin
    rstn_in = 1'b0;
    {s_axi_awvalid_in, s_axi_wvalid_in, s_axi_bready_in, s_axi_arvalid_in, s_axi_rready_in} = '0;
    {watchdog_reset_in, port_data_in, fc_clk_in, cpu_rd_in, cpu_wr_in, mode_strap_pin_in} = '0;
    {s_axi_awaddr_in, s_axi_wdata_in, s_axi_araddr_in, cpu_addr_in} = '0;
    s_axi_wstrb_in = 4'hf;
    cpu_be_in = 4'h5;
    reset_vector_in = 32'h0010_0003;
    rst(1'b0);
    rd(MC, 32'h80);
    rd(ST, 32'h08);
    ra(32'h0008_0000, 6'h20);
    wr(MC, 32'h00);
    pn(1'b1, 1'b0, 1'b1);
    pn(1'b0, 1'b1, 1'b0);
    wr(MC, 32'h80);
    wr(MC, 32'h81);
    rd(MC, 32'h81);
    rd(ST, 32'h0a);
    ra(32'h0008_0000, 6'h10);
    ra(32'hffe0_0000, 6'h08);
    ra(32'h0200_0000, 6'h20);
    stb(9'h0af);
    wr(MC, 32'h85);
    stb(9'h1fa);
    wr(MC, 32'h86);
    rd(MC, 32'h85);
    wr(MC, 32'h01);
    tog = shared_clock_port_pin_out;
    @(posedge clk_sys_in);
    chk(shared_clock_port_pin_out, !tog);
    wr(MC, 32'h81);
    wr(CK, 32'h01);
    pn(1'b0, 1'b1, 1'b1);
    wr(CK, 32'h02);
    tog = shared_clock_port_pin_out;
    repeat (4) @(posedge clk_sys_in);
    chk(shared_clock_port_pin_out, !tog);
    wr(CK, 32'h03);
    tog = shared_clock_port_pin_out;
    repeat (16) @(posedge clk_sys_in);
    chk(shared_clock_port_pin_out, !tog);
    wr(CK, 32'h00);
    ra(32'h0000_0400, 6'h02);
    wr(MC, 32'h83);
    ra(32'hffe0_0000, 6'h10);
    chk(ext_bus_width_out, 2'h3);
    wr(MC, 32'h8b);
    rd(MC, 32'h83);
    wr(MC, 32'h87);
    watchdog_reset_in <= 1'b1;
    @(posedge clk_sys_in);
    watchdog_reset_in <= 1'b0;
    repeat (4) @(posedge clk_sys_in);
    rd(MC, 32'h83);
    acc(1'b0, 32'h0004_0050, 32'h0, 32'h0, 2'h2);
    chk(ext_wr_count, 2);
    rst(1'b1);
    rd(MC, 32'h03);
    rd(ST, 32'h0f);
    ra(32'h0008_0000, 6'h10);
    wr(MC, 32'h01);
    ra(32'hffe0_0000, 6'h20);
    ra(32'h0006_0000, 6'h04);
    wr(MC, 32'h00);
    rd(ST, 32'h0d);
    end_of_test();
  end
endmodule
